// ==== ncl_loader.sv ====
// Configuration and calibration space: startup loader plus Wishbone read/write port.
// Assumes a classic Wishbone master on clk_i and consumers that sample the
// configuration outputs once cfg_valid_o is high.
//
// Register access over Wishbone was decided locally.
`timescale 1ns/100ps

// What this block does
// RULE1 - At startup copy the automatic calibration row into its target register unaided.
// RULE2 - Load the user row at power-on; software reads it at its fixed address.
// RULE3 - A rewritten user row takes effect only after the next reset.
// RULE4 - User row bits 2:0 give the boot-protected size, default 7.
// RULE5 - User row bits 6:4 give the emulated EEPROM size, default 7.
// RULE6 - User row bits 13:8 give the supply brown-out threshold, default 0x22.
// RULE7 - Supply brown-out enable bit 14, action bits 16:15, hysteresis bit 40.
// RULE8 - Software rewriting the row keeps core brown-out bits 24:17 and 41.
// RULE9 - Watchdog enable bit 25, always-on bit 26, window enable bit 39, default 0.
// RULE10 - Watchdog period 30:27, window 34:31, early warning 38:35 from the row.
// RULE11 - User row bits 63:48 hold one flash region lock bit each, default 0xFFFF.
// RULE12 - Software calibration area is readable and ignores every write.
// RULE13 - Software copies converter linearity and bias bits into the converter.
// RULE14 - Software copies oscillator bits 44:38 and loop coarse bits 63:58.
// RULE15 - A 128-bit serial number is readable as four words at fixed addresses.
// RULE16 - Software uses all 128 serial bits for uniqueness.
// RULE17 - Reserved row bits are ignored by logic and kept by software.
module ncl_loader #(
  parameter logic [31:0]  AUTO_CAL_ROW  = 32'h1234_5678, // Arbitrary value
  parameter logic [127:0] SW_CAL_AREA   = 128'h0000_0000_0000_0000_fc1a_5f42_0000_0000,
  parameter logic [127:0] SERIAL_NUMBER = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [31:0]      adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  output logic                  err_o,
  output ncl_pkg::ncl_cfg_t     cfg_o,
  output logic      [31:0]      auto_cal_o,
  output logic                  cfg_valid_o,
  output logic                  row_pending_o
);

  // Non-volatile copy of the user row; it survives rst_i like flash does
  logic [63:0]             urow_store_r = ncl_pkg::UROW_DEFAULT;
  logic [63:0]             urow_store_nxt;
  // Settings in force since the last reset
  ncl_pkg::ncl_cfg_t       cfg_r;
  ncl_pkg::ncl_cfg_t       cfg_nxt;
  logic [31:0]             auto_cal_r;
  logic [31:0]             auto_cal_nxt;
  ncl_pkg::ncl_state_t     state_r;
  ncl_pkg::ncl_state_t     state_nxt;
  logic                    pending_r;
  logic                    pending_nxt;
  logic                    ack_r;
  logic                    err_r;
  logic [31:0]             dat_r;
  logic [31:0]             dat_nxt;

  // Split a user row into the settings the consumers need
  function automatic ncl_pkg::ncl_cfg_t decode_row(input logic [63:0] row);
    ncl_pkg::ncl_cfg_t c;
    c.boot_protect_size    = row[ncl_pkg::BOOT_MSB:ncl_pkg::BOOT_LSB];    // RULE4
    c.eeprom_size          = row[ncl_pkg::EE_MSB:ncl_pkg::EE_LSB];        // RULE5
    c.bod_level            = row[ncl_pkg::BODL_MSB:ncl_pkg::BODL_LSB];    // RULE6
    c.bod_enable           = row[ncl_pkg::BODEN_BIT];                     // RULE7
    c.bod_action           = row[ncl_pkg::BODA_MSB:ncl_pkg::BODA_LSB];    // RULE7
    c.bod_hysteresis       = row[ncl_pkg::BODH_BIT];                      // RULE7
    // Production-set core brown-out settings pass through untouched
    c.core_bod_cfg         = {row[ncl_pkg::CBOD_X_BIT],
                              row[ncl_pkg::CBOD_MSB:ncl_pkg::CBOD_LSB]};
    c.wdt_enable           = row[ncl_pkg::WDTEN_BIT];                     // RULE9
    c.wdt_always_on        = row[ncl_pkg::WDTAO_BIT];                     // RULE9
    c.wdt_window_enable    = row[ncl_pkg::WWEN_BIT];                      // RULE9
    c.wdt_period           = row[ncl_pkg::WPER_MSB:ncl_pkg::WPER_LSB];    // RULE10
    c.wdt_window           = row[ncl_pkg::WWIN_MSB:ncl_pkg::WWIN_LSB];    // RULE10
    c.early_warning_offset = row[ncl_pkg::WEW_MSB:ncl_pkg::WEW_LSB];      // RULE10
    c.region_lock          = row[ncl_pkg::LOCK_MSB:ncl_pkg::LOCK_LSB];    // RULE11
    return c;
  endfunction

  // Byte-lane merge of a write into one stored word
  function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  sel);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // Address decode
  wire logic hit_urow_lo = (adr_i == ncl_pkg::ADDR_UROW_LO);
  wire logic hit_urow_hi = (adr_i == ncl_pkg::ADDR_UROW_HI);
  wire logic hit_status  = (adr_i == ncl_pkg::ADDR_STATUS);
  wire logic hit_cal0    = (adr_i == ncl_pkg::ADDR_CAL_W0);
  wire logic hit_cal1    = (adr_i == ncl_pkg::ADDR_CAL_W1);
  wire logic hit_cal2    = (adr_i == ncl_pkg::ADDR_CAL_W2);
  wire logic hit_cal3    = (adr_i == ncl_pkg::ADDR_CAL_W3);
  wire logic hit_sn0     = (adr_i == ncl_pkg::ADDR_SN_W0);
  wire logic hit_sn1     = (adr_i == ncl_pkg::ADDR_SN_W1);
  wire logic hit_sn2     = (adr_i == ncl_pkg::ADDR_SN_W2);
  wire logic hit_sn3     = (adr_i == ncl_pkg::ADDR_SN_W3);
  wire logic hit_cal     = hit_cal0 | hit_cal1 | hit_cal2 | hit_cal3;
  wire logic hit_sn      = hit_sn0 | hit_sn1 | hit_sn2 | hit_sn3;
  wire logic hit_any     = hit_urow_lo | hit_urow_hi | hit_status | hit_cal | hit_sn;

  // Requests wait until the startup load has finished
  wire logic loader_ready = (state_r == ncl_pkg::ST_READY);
  wire logic req          = cyc_i & stb_i & ~ack_r & ~err_r & loader_ready;
  wire logic req_ok       = req & hit_any;
  wire logic req_bad      = req & ~hit_any;
  wire logic wr_urow_lo   = req_ok & we_i & hit_urow_lo;
  wire logic wr_urow_hi   = req_ok & we_i & hit_urow_hi;

  wire logic [31:0] status_word = {{30{1'b0}}, pending_r, loader_ready};

  // Read data: serial number and calibration words come straight from constants
  assign dat_nxt =
      hit_urow_lo ? urow_store_r[31:0]                         :  // RULE2
      hit_urow_hi ? urow_store_r[63:32]                        :  // RULE2
      hit_status  ? status_word                                :
      hit_cal0    ? SW_CAL_AREA[31:0]                          :  // RULE12
      hit_cal1    ? SW_CAL_AREA[63:32]                         :  // RULE12
      hit_cal2    ? SW_CAL_AREA[95:64]                         :  // RULE12
      hit_cal3    ? SW_CAL_AREA[127:96]                        :  // RULE12
      hit_sn0     ? SERIAL_NUMBER[31:0]                        :  // RULE15
      hit_sn1     ? SERIAL_NUMBER[63:32]                       :  // RULE15
      hit_sn2     ? SERIAL_NUMBER[95:64]                       :  // RULE15
      hit_sn3     ? SERIAL_NUMBER[127:96]                      :  // RULE15
                    32'h0000_0000;

  // Stored row changes on software writes; the loaded settings do not
  assign urow_store_nxt = {
      wr_urow_hi ? merge_word(urow_store_r[63:32], dat_i, sel_i) : urow_store_r[63:32],
      wr_urow_lo ? merge_word(urow_store_r[31:0],  dat_i, sel_i) : urow_store_r[31:0]};

  // Startup sequence
  always_comb begin
    state_nxt    = state_r;
    cfg_nxt      = cfg_r;
    auto_cal_nxt = auto_cal_r;
    case (state_r)
      ncl_pkg::ST_RESET: begin
        state_nxt = ncl_pkg::ST_LOAD_CAL;
      end
      ncl_pkg::ST_LOAD_CAL: begin
        auto_cal_nxt = AUTO_CAL_ROW;                    // RULE1
        state_nxt    = ncl_pkg::ST_LOAD_ROW;
      end
      ncl_pkg::ST_LOAD_ROW: begin
        cfg_nxt   = decode_row(urow_store_r);           // RULE2
        state_nxt = ncl_pkg::ST_READY;
      end
      ncl_pkg::ST_READY: begin
        state_nxt = ncl_pkg::ST_READY;                  // RULE3
      end
      default: begin
        state_nxt = ncl_pkg::ST_RESET;
      end
    endcase
  end

  // Pending: the stored row has been written since the startup load, even with unchanged data
  assign pending_nxt = (wr_urow_lo | wr_urow_hi) ? 1'b1 : pending_r;  // RULE3

  always_ff @(posedge clk_i) begin
    urow_store_r <= urow_store_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= ncl_pkg::ST_RESET;
      cfg_r      <= decode_row(ncl_pkg::UROW_DEFAULT);
      auto_cal_r <= 32'h0000_0000;
      pending_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cfg_r      <= cfg_nxt;
      auto_cal_r <= auto_cal_nxt;
      pending_r  <= pending_nxt;
    end
  end

  // Bus answer: one cycle after the request is taken, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req_ok;                                  // RULE12
      err_r <= req_bad;
      dat_r <= (req_ok & ~we_i) ? dat_nxt : 32'h0000_0000;
    end
  end

  assign dat_o         = dat_r;
  assign ack_o         = ack_r;
  assign err_o         = err_r;
  assign cfg_o         = cfg_r;
  assign auto_cal_o    = auto_cal_r;
  assign cfg_valid_o   = loader_ready;
  assign row_pending_o = pending_r;

endmodule // ncl_loader

// ==== ncl_loader_assertions.sv ====
// Bus answer and startup load checks for the configuration row loader.
// Assumes one clock domain; bound to every ncl_loader instance.
`timescale 1ns/100ps
module ncl_loader_assertions #(
  parameter logic [31:0] AUTO_CAL_ROW = 32'h0
) (
  input logic              clk_i,
  input logic              rst_i,
  input logic              cyc_i,
  input logic              stb_i,
  input logic              we_i,
  input logic [31:0]       adr_i,
  input logic [3:0]        sel_i,
  input logic [31:0]       dat_i,
  input logic [31:0]       dat_o,
  input logic              ack_o,
  input logic              err_o,
  input ncl_pkg::ncl_cfg_t cfg_o,
  input logic [31:0]       auto_cal_o,
  input logic              cfg_valid_o,
  input logic              row_pending_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire wr_row = we_i && (adr_i == ncl_pkg::ADDR_UROW_LO || adr_i == ncl_pkg::ADDR_UROW_HI);
  ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack held");
  err_pulse_a: assert property (err_o |=> !err_o) else $error("err held");
  ans_excl_a: assert property (!(ack_o && err_o)) else $error("ack with err");
  idle_zero_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("data off ack");
  ans_cause_a: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i && cfg_valid_o))
    else $error("answer without request");
  startup_a: assert property ($fell(rst_i) |-> !cfg_valid_o ##[1:3] cfg_valid_o)
    else $error("startup load late");
  cal_load_a: assert property (cfg_valid_o |-> auto_cal_o == AUTO_CAL_ROW)
    else $error("auto cal wrong");
  cfg_hold_a: assert property (cfg_valid_o && $past(cfg_valid_o) |-> $stable(cfg_o))
    else $error("settings moved");
  pend_set_a: assert property (ack_o && $past(wr_row) |-> row_pending_o)
    else $error("pending not set");
  pend_keep_a: assert property (row_pending_o |=> row_pending_o) else $error("pending lost");
  cover property (ack_o && $past(wr_row));
  cover property (err_o);
  cover property ($rose(cfg_valid_o));
endmodule // ncl_loader_assertions

bind ncl_loader ncl_loader_assertions #(.AUTO_CAL_ROW(AUTO_CAL_ROW)) ncl_loader_assertions_inst (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
  .err_o, .cfg_o, .auto_cal_o, .cfg_valid_o, .row_pending_o);

// ==== ncl_pkg.sv ====
// Constants, field layout and carrier types for the configuration row loader.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package ncl_pkg;

  // Byte addresses of the readable words
  localparam logic [31:0] ADDR_UROW_LO = 32'h0080_4000;
  localparam logic [31:0] ADDR_UROW_HI = 32'h0080_4004;
  localparam logic [31:0] ADDR_STATUS  = 32'h0080_4010;
  localparam logic [31:0] ADDR_CAL_W0  = 32'h0080_6020;
  localparam logic [31:0] ADDR_CAL_W1  = 32'h0080_6024;
  localparam logic [31:0] ADDR_CAL_W2  = 32'h0080_6028;
  localparam logic [31:0] ADDR_CAL_W3  = 32'h0080_602c;
  localparam logic [31:0] ADDR_SN_W0   = 32'h0080_a00c;
  localparam logic [31:0] ADDR_SN_W1   = 32'h0080_a040;
  localparam logic [31:0] ADDR_SN_W2   = 32'h0080_a044;
  localparam logic [31:0] ADDR_SN_W3   = 32'h0080_a048;

  // Value of an unprogrammed user row
  localparam logic [63:0] UROW_DEFAULT = 64'hffff_005a_d8e0_e277;

  // User row field positions
  localparam int BOOT_LSB   = 0;
  localparam int BOOT_MSB   = 2;
  localparam int EE_LSB     = 4;
  localparam int EE_MSB     = 6;
  localparam int BODL_LSB   = 8;
  localparam int BODL_MSB   = 13;
  localparam int BODEN_BIT  = 14;
  localparam int BODA_LSB   = 15;
  localparam int BODA_MSB   = 16;
  localparam int CBOD_LSB   = 17;
  localparam int CBOD_MSB   = 24;
  localparam int WDTEN_BIT  = 25;
  localparam int WDTAO_BIT  = 26;
  localparam int WPER_LSB   = 27;
  localparam int WPER_MSB   = 30;
  localparam int WWIN_LSB   = 31;
  localparam int WWIN_MSB   = 34;
  localparam int WEW_LSB    = 35;
  localparam int WEW_MSB    = 38;
  localparam int WWEN_BIT   = 39;
  localparam int BODH_BIT   = 40;
  localparam int CBOD_X_BIT = 41;
  localparam int LOCK_LSB   = 48;
  localparam int LOCK_MSB   = 63;

  // Status word bit positions
  localparam int ST_READY_BIT   = 0;
  localparam int ST_PENDING_BIT = 1;

  typedef enum {ST_RESET, ST_LOAD_CAL, ST_LOAD_ROW, ST_READY} ncl_state_t;

  // Power-on settings handed to the consuming modules
  typedef struct packed {
    logic [2:0]  boot_protect_size;
    logic [2:0]  eeprom_size;
    logic [5:0]  bod_level;
    logic        bod_enable;
    logic [1:0]  bod_action;
    logic        bod_hysteresis;
    logic [8:0]  core_bod_cfg;
    logic        wdt_enable;
    logic        wdt_always_on;
    logic        wdt_window_enable;
    logic [3:0]  wdt_period;
    logic [3:0]  wdt_window;
    logic [3:0]  early_warning_offset;
    logic [15:0] region_lock;
  } ncl_cfg_t;

endpackage

// ==== testbench.sv ====
// Self-checking bench for the configuration row loader.
// Assumes the default parameter values of ncl_loader.
`timescale 1ns/100ps
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, dat_o, auto_cal_o, q;
  logic [3:0] sel_i = 4'h0;
  logic ack_o, err_o, cfg_valid_o, row_pending_o, e;
  ncl_pkg::ncl_cfg_t cfg_o;
  int n_fail = 0, n_checks = 0;
  localparam logic [127:0] CAL = 128'h0000_0000_0000_0000_fc1a_5f42_0000_0000;
  localparam logic [127:0] SN = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978;
  localparam logic [55:0] CFG_DEF = {3'h7, 3'h7, 6'h22, 1'b1, 2'h1, 1'b0, 9'h070, 1'b0, 1'b0,
    1'b0, 4'hb, 4'h5, 4'hb, 16'hffff};
  localparam logic [55:0] CFG_NEW = {3'h2, 3'h5, 6'h15, 1'b0, 2'h2, 1'b1, 9'h070, 1'b1, 1'b1,
    1'b1, 4'h3, 4'ha, 4'h6, 16'h1234};
  always #20 clk_i = ~clk_i;
  ncl_loader ncl_loader_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .cfg_o(cfg_o), .auto_cal_o(auto_cal_o), .cfg_valid_o(cfg_valid_o),
    .row_pending_o(row_pending_o));
  task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
    n_checks++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", n, x, g);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    // Answer and read data are taken at the rising edge that sees ack high
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && k < 50);
    q = dat_o;
    e = err_o;
    {cyc_i, stb_i, we_i} <= 3'b000;
    chk("answer", 1, k < 50);
  endtask
  task automatic reset_dut();
    int k;
    k = 0;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    do begin
      @(negedge clk_i);
      k++;
    end while (cfg_valid_o !== 1'b1 && k < 20);
  endtask
  task automatic t_defaults();
    chk("auto_cal", 32'h1234_5678, auto_cal_o);
    chk("cfg", CFG_DEF, cfg_o);
    bus(0, ncl_pkg::ADDR_UROW_LO, 0, 0);
    chk("row_lo", ncl_pkg::UROW_DEFAULT[31:0], q);
    bus(0, ncl_pkg::ADDR_UROW_HI, 0, 0);
    chk("row_hi", ncl_pkg::UROW_DEFAULT[63:32], q);
    bus(0, ncl_pkg::ADDR_STATUS, 0, 0);
    chk("status", 32'h0000_0001, q);
  endtask
  task automatic t_rewrite();
    bus(1, ncl_pkg::ADDR_UROW_LO, 32'h1ee1_15da, 4'hf);
    bus(1, ncl_pkg::ADDR_UROW_HI, 32'h1234_fdb5, 4'hf);
    chk("pending", 1, row_pending_o);
    chk("cfg_kept", CFG_DEF, cfg_o);
    bus(0, ncl_pkg::ADDR_UROW_HI, 0, 0);
    chk("row_hi_new", 32'h1234_fdb5, q);
    bus(0, ncl_pkg::ADDR_STATUS, 0, 0);
    chk("status_pend", 32'h0000_0003, q);
    reset_dut();
    chk("pending_rst", 0, row_pending_o);
    chk("cfg_new", CFG_NEW, cfg_o);
  endtask
  task automatic t_cal_serial();
    logic [31:0] sa [4];
    logic [127:0] cw;
    logic [127:0] sw;
    sa = '{ncl_pkg::ADDR_SN_W0, ncl_pkg::ADDR_SN_W1, ncl_pkg::ADDR_SN_W2, ncl_pkg::ADDR_SN_W3};
    bus(1, ncl_pkg::ADDR_CAL_W1, 32'hffff_ffff, 4'hf);
    chk("cal_wr_err", 0, e);
    for (int i = 0; i < 4; i++) begin
      bus(0, ncl_pkg::ADDR_CAL_W0 + 32'(4 * i), 0, 0);
      chk("cal_word", CAL[32*i+:32], q);
      cw[32*i+:32] = q;
      bus(0, sa[i], 0, 0);
      chk("serial_word", SN[32*i+:32], q);
      sw[32*i+:32] = q;
    end
    chk("cal_linearity", CAL[34:27], cw[34:27]);
    chk("cal_bias", CAL[37:35], cw[37:35]);
    chk("cal_osc", CAL[44:38], cw[44:38]);
    chk("cal_coarse", CAL[63:58], cw[63:58]);
    chk("serial_lo", SN[63:0], sw[63:0]);
    chk("serial_hi", SN[127:64], sw[127:64]);
    bus(0, 32'h0080_4008, 0, 0);
    chk("unmapped_err", 1, e);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    stop_test();
  end
  initial begin
    reset_dut();
    t_defaults();
    t_rewrite();
    t_cal_serial();
    stop_test();
  end
endmodule // testbench
